/* logic/tsr_pkg.sv */
// Shared constants for the temperature result read block
package tsr_pkg;
  localparam logic [3:0]  DEV_ADDR_PREFIX  = 4'h9;
  localparam int          ADDR_SEL_W       = 3;
  localparam int          BYTE_W           = 8;
  localparam logic [7:0]  PTR_TEMP_RESULT  = 8'h00;
  localparam logic [7:0]  PTR_LAST_VALID   = 8'h03;
  localparam logic [7:0]  PTR_RESET        = 8'h00;
  localparam int          RESULT_W         = 16;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam int          CONV_W           = 12;
  localparam int          SIGN_BIT         = 15;
  localparam logic [1:0]  RES_9BIT         = 2'h0;
  localparam logic [1:0]  RES_10BIT        = 2'h1;
  localparam logic [1:0]  RES_11BIT        = 2'h2;
  localparam logic [1:0]  RES_12BIT        = 2'h3;
  localparam int          LSB_9BIT         = 7;
  localparam int          LSB_10BIT        = 6;
  localparam int          LSB_11BIT        = 5;
  localparam int          LSB_12BIT        = 4;
  localparam logic        RW_READ          = 1'b1;
  localparam logic        BIT_ACK          = 1'b0;
  localparam logic        BIT_NACK         = 1'b1;
  // Host-side wait before trusting the first result, per resolution
  localparam int          CONV_TIME_9_MS   = 25;
  localparam int          CONV_TIME_10_MS  = 50;
  localparam int          CONV_TIME_11_MS  = 100;
  localparam int          CONV_TIME_12_MS  = 200;
endpackage

/* logic/tsr_sync.sv */
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module tsr_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("tsr_sync needs WIDTH of at least one");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* logic/tsr_result_regs.sv */
// Pointer and temperature result register access over the two-wire serial link
// Functional notes
// RULE1 - Pointer write: Start, address 1001 plus select pins, write bit zero.
// RULE2 - After address acknowledge, the next data byte loads the register pointer.
// RULE3 - Reset leaves the pointer selecting the result register.
// RULE4 - Sixteen-bit read-only result holds the latest completed conversion.
// RULE5 - Result is two's complement, left-justified, unused low bits zero.
// RULE6 - Bit 15 is the sign, one for negative temperatures.
// RULE7 - Valid bits end at 4, 5, 6 or 7 for 12 to 9 bit resolution.
// RULE8 - Reading never disturbs the conversion running in the background.
// RULE9 - A finished conversion loads only when no read is in progress.
// RULE10 - The master must have the pointer on the result register to read it.
// RULE11 - Read: Start, address 1001 plus select pins, read bit; matching address acknowledged.
// RULE12 - Upper byte goes first; master acknowledge requests the lower byte.
// RULE13 - Master NACK after the lower byte makes the device release data.
// RULE14 - Master ACK after the lower byte restarts with a fresh upper byte.
// RULE15 - Master NACK after the upper byte suppresses the lower byte.
// RULE16 - Result reads zero after reset until a conversion completes.
// RULE17 - Writes to the result register are ignored and answered with NACK.
// RULE18 - The master should wait one conversion time before trusting results.
// RULE19 - Pointer values above three are acknowledged but leave the pointer alone.
// RULE20 - The pointer keeps its selection across reads until rewritten.
// RULE21 - Resolution codes 00 to 11 select 9 to 12 valid result bits.
// RULE22 - At 12 bits, bit 4 weighs 0.0625 degrees, doubling upward.
`timescale 1ns/1ps
module tsr_result_regs #(
  parameter int CONV_W = tsr_pkg::CONV_W
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          scl,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_n,
  input  wire logic [tsr_pkg::ADDR_SEL_W-1:0] addr_select_pins,
  input  wire logic [1:0]                    resolution_select,
  input  wire logic                          conv_done,
  input  wire logic [CONV_W-1:0]             conv_value,
  output logic      [tsr_pkg::RESULT_W-1:0]  temperature_result,
  output logic                               read_in_progress,
  output logic      [tsr_pkg::BYTE_W-1:0]    reg_pointer
);

  if (CONV_W + tsr_pkg::LSB_12BIT != tsr_pkg::RESULT_W) begin : g_chk
    $error("CONV_W must fill the result word down to the 12-bit LSB");
  end

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_TX,
    ST_TX_ACK
  } tsr_state_t;

  // Converter code placed at the top, low bits cleared below the resolution
  function automatic logic [15:0] fmt_result(input logic [CONV_W-1:0] code,
                                             input logic [1:0]        res);
    logic [15:0] word;
    int          lsb;
    word = {code, 4'h0}; // RULE5 RULE6 RULE22
    lsb  = tsr_pkg::LSB_12BIT;
    unique case (res)
      tsr_pkg::RES_9BIT:  lsb = tsr_pkg::LSB_9BIT;
      tsr_pkg::RES_10BIT: lsb = tsr_pkg::LSB_10BIT;
      tsr_pkg::RES_11BIT: lsb = tsr_pkg::LSB_11BIT;
      tsr_pkg::RES_12BIT: lsb = tsr_pkg::LSB_12BIT;
    endcase
    return word & (16'hFFFF << lsb); // RULE7 RULE21
  endfunction

  // Address byte match against prefix and strapped select pins
  function automatic logic addr_hit(input logic [7:0] byte_in,
                                    input logic [2:0] sel);
    return (byte_in[7:4] == tsr_pkg::DEV_ADDR_PREFIX) && (byte_in[3:1] == sel); // RULE1 RULE11
  endfunction

  // ------------------------------------------------------------------
  // Link domain: clocked by the master's serial clock, except the start and stop detectors, which are clocked by data edges
  // ------------------------------------------------------------------
  logic        lrst_n;
  logic [2:0]  addr_sel;
  logic        start_tgl = 1'b0;
  logic        stop_tgl = 1'b0;
  logic        start_seen;
  logic        start_now;
  tsr_state_t  state;
  logic [2:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [7:0]  tx_low;
  logic        tx_second;
  logic        rd_busy_l;
  logic        stop_ref_l;
  logic [15:0] tx_word;

  // Link reset follows the core reset, so the master must clock during reset
  tsr_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_link_rst (
    .clk   (scl),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (lrst_n)
  );

  tsr_sync #(
    .WIDTH     (tsr_pkg::ADDR_SEL_W),
    .RESET_VAL (3'h0)
  ) u_addr_sync (
    .clk   (scl),
    .rst_n (lrst_n),
    .d     (addr_select_pins),
    .q     (addr_sel)
  );

  // Start and stop are data edges while the clock is high; no reset exists there
  always_ff @(negedge sda_in) begin
    if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge sda_in) begin
    if (scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // Toggle is stable a half period before this edge, so no extra stages
  always_ff @(posedge scl) begin
    if (!lrst_n) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= start_tgl;
    end
  end

  assign start_now = start_tgl != start_seen;

  // Result word chosen for transmission by the current pointer
  assign tx_word = (reg_pointer == tsr_pkg::PTR_TEMP_RESULT) ? temperature_result : 16'h0000;

  always_ff @(posedge scl) begin
    if (!lrst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      rx_shift  <= 8'h00;
      tx_shift  <= 8'h00;
      tx_low    <= 8'h00;
      tx_second <= 1'b0;
    end else if (start_now) begin
      state    <= ST_ADDR;
      bit_cnt  <= 3'h1;
      rx_shift <= {7'h00, sda_in};
    end else begin
      unique case (state)
        ST_IDLE: begin
          bit_cnt <= 3'h0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          rx_shift <= {rx_shift[6:0], sda_in};
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            unique case (state)
              ST_ADDR: state <= ST_ADDR_ACK;
              ST_PTR:  state <= ST_PTR_ACK;
              default: state <= ST_WDATA_ACK;
            endcase
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= 3'h0;
          if (!addr_hit(rx_shift, addr_sel)) begin
            state <= ST_IDLE;
          end else if (rx_shift[0] == tsr_pkg::RW_READ) begin
            // Word is frozen in the core domain since the start
            tx_shift  <= tx_word[15:8]; // RULE12
            tx_low    <= tx_word[7:0];
            tx_second <= 1'b0;
            state     <= ST_TX;
          end else begin
            state <= ST_PTR; // RULE2
          end
        end
        ST_PTR_ACK: begin
          bit_cnt <= 3'h0;
          state   <= ST_WDATA;
        end
        ST_WDATA_ACK: begin
          bit_cnt <= 3'h0;
          state   <= ST_WDATA;
        end
        ST_TX: begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            state <= ST_TX_ACK;
          end
        end
        ST_TX_ACK: begin
          bit_cnt <= 3'h0;
          if (sda_in == tsr_pkg::BIT_NACK) begin
            state <= ST_IDLE; // RULE13 RULE15
          end else if (tx_second) begin
            tx_shift  <= tx_word[15:8]; // RULE14
            tx_low    <= tx_word[7:0];
            tx_second <= 1'b0;
            state     <= ST_TX;
          end else begin
            tx_shift  <= tx_low; // RULE12
            tx_second <= 1'b1;
            state     <= ST_TX;
          end
        end
      endcase
    end
  end

  // Pointer survives reads; only the first byte after a write address loads it
  always_ff @(posedge scl) begin
    if (!lrst_n) begin
      reg_pointer <= tsr_pkg::PTR_RESET; // RULE3
    end else if (!start_now && state == ST_PTR_ACK && rx_shift <= tsr_pkg::PTR_LAST_VALID) begin
      reg_pointer <= rx_shift; // RULE2 RULE19 RULE20
    end
  end

  // Read-busy spans start to end of read; write or foreign address drops it
  always_ff @(posedge scl) begin
    if (!lrst_n) begin
      rd_busy_l  <= 1'b0;
      stop_ref_l <= 1'b0;
    end else if (start_now) begin
      rd_busy_l  <= 1'b1;
      stop_ref_l <= stop_tgl;
    end else if (state == ST_ADDR_ACK &&
                 !(addr_hit(rx_shift, addr_sel) && rx_shift[0] == tsr_pkg::RW_READ)) begin
      rd_busy_l <= 1'b0;
    end else if (state == ST_TX_ACK && sda_in == tsr_pkg::BIT_NACK) begin
      rd_busy_l <= 1'b0;
    end
  end

  // Data changes only while the clock is low
  always_ff @(negedge scl) begin
    sda_out <= 1'b0;
    if (!lrst_n) begin
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_TX_ACK: begin
          sda_oe_n <= 1'b1; // RULE13 RULE15
        end
        ST_ADDR_ACK: begin
          sda_oe_n <= !addr_hit(rx_shift, addr_sel); // RULE11
        end
        ST_PTR_ACK: begin
          sda_oe_n <= tsr_pkg::BIT_ACK; // RULE19
        end
        ST_WDATA_ACK: begin
          sda_oe_n <= (reg_pointer == tsr_pkg::PTR_TEMP_RESULT); // RULE17
        end
        ST_TX: begin
          sda_oe_n <= tx_shift[7]; // RULE12
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Core domain: result register and conversion interlock
  // ------------------------------------------------------------------
  logic        busy_s;
  logic        stop_s;
  logic        stop_ref_s;
  logic        read_hold;
  logic        pend_valid;
  logic [15:0] pend_value;

  tsr_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_busy_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({rd_busy_l, stop_tgl, stop_ref_l}),
    .q     ({busy_s, stop_s, stop_ref_s})
  );

  // A stop since the start ends the hold even if the read was cut short
  assign read_hold = busy_s && (stop_s == stop_ref_s);

  // Conversions arrive regardless of reads; a held result is parked, not lost
  // Gated on the registered hold so the result never moves while the flag reads high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      temperature_result <= tsr_pkg::RESULT_RESET; // RULE16
      pend_value         <= tsr_pkg::RESULT_RESET;
      pend_valid         <= 1'b0;
    end else if (conv_done && read_in_progress) begin
      pend_value <= fmt_result(conv_value, resolution_select); // RULE8 RULE9
      pend_valid <= 1'b1;
    end else if (conv_done) begin
      temperature_result <= fmt_result(conv_value, resolution_select); // RULE4
      pend_valid         <= 1'b0;
    end else if (pend_valid && !read_in_progress) begin
      temperature_result <= pend_value; // RULE9
      pend_valid         <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_in_progress <= 1'b0;
    end else begin
      read_in_progress <= read_hold;
    end
  end

endmodule

/* tb/tsr_i2c_master.sv */
// Serial bus master model for the result block
`timescale 1ns/1ps
module tsr_i2c_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Clock only runs inside frames or reset
  task automatic clocks(input int n);
    repeat (n) begin
      #32 scl = 1'b0;
      #32 scl = 1'b1;
    end
  endtask
  task automatic start();
    sda_m = 1'b1;
    #16 scl = 1'b1;
    #16 sda_m = 1'b0;
    #16 scl = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #16 scl = 1'b1;
    #16 sda_m = 1'b1;
    #16;
  endtask
  // Data set mid-low, sampled at the rising edge
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #16 scl = 1'b1;
    r = sda;
    #32 scl = 1'b0;
    #16;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, a);
  endtask
  // Ack requests more, nack ends the read
  task automatic rd_byte(input logic ak, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(ak, r);
  endtask
endmodule

/* tb/tsr_result_regs_monitor.sv */
// Port checker for the temperature result block
`timescale 1ns/1ps
module tsr_result_regs_monitor #(
  parameter int CONV_W = 12
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              scl,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe_n,
  input wire logic [2:0]        addr_select_pins,
  input wire logic [1:0]        resolution_select,
  input wire logic              conv_done,
  input wire logic [CONV_W-1:0] conv_value,
  input wire logic [15:0]       temperature_result,
  input wire logic              read_in_progress,
  input wire logic [7:0]        reg_pointer
);
  function automatic logic [15:0] tsr_fmt(logic [CONV_W-1:0] v, logic [1:0] r);
    return {v, 4'h0} & (16'hFFFF << (7 - r));
  endfunction
  // A hold spans at least four core clock cycles
  sequence s_held;
    read_in_progress [*4];
  endsequence
  a_conv_load: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !read_in_progress |=> temperature_result == tsr_fmt($past(conv_value), $past(resolution_select)))
    else $error("conversion not loaded");
  a_sign_bit: assert property (@(posedge clk) disable iff (!rst_n)
    conv_done && !read_in_progress |=> temperature_result[15] == $past(conv_value[CONV_W-1]))
    else $error("sign bit wrong");
  a_low_nibble: assert property (@(posedge clk) disable iff (!rst_n)
    temperature_result[3:0] == 4'h0)
    else $error("low bits not zero");
  a_load_idle: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(temperature_result) |-> !read_in_progress)
    else $error("result changed during read");
  a_hold_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    read_in_progress && $past(read_in_progress) |-> $stable(temperature_result))
    else $error("result not frozen");
  a_hold_min: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(read_in_progress) |-> s_held)
    else $error("hold too short");
  a_reset_vals: assert property (@(posedge clk)
    !rst_n |=> temperature_result == 16'h0000 && !read_in_progress)
    else $error("reset values wrong");
  a_ptr_range: assert property (@(posedge scl) disable iff (!rst_n)
    reg_pointer <= 8'h03)
    else $error("pointer out of range");
  a_sda_low: assert property (@(posedge scl) disable iff (!rst_n)
    sda_out == 1'b0)
    else $error("data output not open drain");
endmodule
bind tsr_result_regs tsr_result_regs_monitor #(.CONV_W(CONV_W)) u_mon (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_select_pins(addr_select_pins), .resolution_select(resolution_select), .conv_done(conv_done),
  .conv_value(conv_value), .temperature_result(temperature_result),
  .read_in_progress(read_in_progress), .reg_pointer(reg_pointer)
);

/* tb/tsr_result_regs_tb.sv */
// Self-checking bench for the temperature result block
`timescale 1ns/1ps
module tsr_result_regs_tb;
  logic        clk, rst_n, scl, sda_m, sda, conv_done, rip, a, a2;
  logic [1:0]  resolution_select;
  logic [2:0]  addr_select_pins;
  logic [11:0] conv_value;
  logic [15:0] temperature_result, w;
  logic [7:0]  reg_pointer, b1, b2, b3, b4;
  logic        sda_oe_n;
  int          error_cnt, checked;
  // Pull-up: released or unknown reads high
  assign sda = (sda_oe_n === 1'b0 || sda_m === 1'b0) ? 1'b0 : 1'b1;
  tsr_i2c_master u_tsr_i2c_master (.scl(scl), .sda_m(sda_m), .sda(sda));
  tsr_result_regs u_tsr_result_regs (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
    .addr_select_pins(addr_select_pins), .resolution_select(resolution_select), .conv_done(conv_done),
    .conv_value(conv_value), .temperature_result(temperature_result), .read_in_progress(rip),
    .reg_pointer(reg_pointer));
  always #25 clk = ~clk;
  task automatic final_report();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conv(input logic [11:0] v);
    @(posedge clk);
    #1 conv_done = 1'b1;
    conv_value = v;
    @(posedge clk);
    #1 conv_done = 1'b0;
  endtask
  // Hold release lags the link by a few core cycles
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (rip !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      $display("[FAIL] read_in_progress expected 0 seen %b", rip);
      final_report();
    end else begin
      // Parked value lands one core edge after the hold reads low
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task automatic rd16(output logic [15:0] v, output logic ak);
    u_tsr_i2c_master.start();
    u_tsr_i2c_master.wr_byte({4'h9, addr_select_pins, 1'b1}, ak);
    u_tsr_i2c_master.rd_byte(1'b0, v[15:8]);
    u_tsr_i2c_master.rd_byte(1'b1, v[7:0]);
    u_tsr_i2c_master.stop();
  endtask
  task automatic wr_ptr(input logic [7:0] p, input logic [7:0] d, input bit dat, output logic ak);
    u_tsr_i2c_master.start();
    u_tsr_i2c_master.wr_byte({4'h9, addr_select_pins, 1'b0}, ak);
    u_tsr_i2c_master.wr_byte(p, ak);
    if (dat) u_tsr_i2c_master.wr_byte(d, ak);
    u_tsr_i2c_master.stop();
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_value = 12'h000;
    resolution_select = 2'h3;
    addr_select_pins = 3'h5;
    error_cnt = 0;
    checked = 0;
    u_tsr_i2c_master.clocks(5);
    @(posedge clk);
    #1 rst_n = 1'b1;
    u_tsr_i2c_master.clocks(4);
    rd16(w, a);
    chk("addr ack", 16'h0000, {15'h0, a});
    chk("reset word", 16'h0000, w);
    wait_idle();
    for (int r = 0; r < 4; r++) begin
      resolution_select = r[1:0];
      conv(12'hF5E);
      #1 chk("format", {12'hF5E, 4'h0} & (16'hFFFF << (7 - r)), temperature_result);
    end
    conv(12'h7D0);
    #1 chk("plus 125", 16'h7D00, temperature_result);
    u_tsr_i2c_master.start();
    u_tsr_i2c_master.wr_byte({4'h9, addr_select_pins, 1'b1}, a);
    conv(12'hC90);
    #1 chk("held", 16'h7D00, temperature_result);
    u_tsr_i2c_master.rd_byte(1'b0, b1);
    u_tsr_i2c_master.rd_byte(1'b0, b2);
    u_tsr_i2c_master.rd_byte(1'b0, b3);
    u_tsr_i2c_master.rd_byte(1'b1, b4);
    u_tsr_i2c_master.stop();
    chk("word one", 16'h7D00, {b1, b2});
    chk("word two", 16'h7D00, {b3, b4});
    wait_idle();
    chk("parked", 16'hC900, temperature_result);
    u_tsr_i2c_master.start();
    u_tsr_i2c_master.wr_byte({4'h9, addr_select_pins, 1'b1}, a);
    u_tsr_i2c_master.rd_byte(1'b1, b1);
    u_tsr_i2c_master.rd_byte(1'b1, b2);
    u_tsr_i2c_master.stop();
    chk("upper only", 16'h00C9, {8'h00, b1});
    chk("released", 16'h00FF, {8'h00, b2});
    wr_ptr(8'h05, 8'h00, 1'b0, a);
    chk("bad ptr ack", 16'h0000, {15'h0, a});
    chk("ptr kept", 16'h0000, {8'h00, reg_pointer});
    wr_ptr(8'h02, 8'h00, 1'b0, a);
    chk("ptr set", 16'h0002, {8'h00, reg_pointer});
    rd16(w, a);
    chk("ptr sticky", 16'h0002, {8'h00, reg_pointer});
    chk("other reg", 16'h0000, w);
    wr_ptr(8'h00, 8'h55, 1'b1, a2);
    chk("write nack", 16'h0001, {15'h0, a2});
    wait_idle();
    chk("no write", 16'hC900, temperature_result);
    rd16(w, a);
    chk("read back", 16'hC900, w);
    u_tsr_i2c_master.start();
    u_tsr_i2c_master.wr_byte({4'h9, 3'h2, 1'b1}, a);
    u_tsr_i2c_master.stop();
    chk("wrong addr", 16'h0001, {15'h0, a});
    wait_idle();
    final_report();
  end
endmodule
